// ===== src/spims_core.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Master-select bit one gives master mode, zero gives slave mode.
// - Only master starts; data write loads empty shifter and sets transmitter-empty.
// - Rate field picks bit time 2, 8, 32 or 128 cycles; start within one.
// - Master transfer end sets receiver-full and loads receive register together.
// - Receiver-full clears after status read followed by data read.
// - Writing data register clears transmit interrupt enable.
// - In slave mode serial clock is an input driving the shifter.
// - Slave moves complete byte to receive register and sets receiver-full.
// - Slave accepts any serial clock up to half the bus clock rate.
// - Late slave write: slave sends the received byte still in shift register.
// - Slave write during transfer waits in buffer until transfer ends.
// - Slave starts on select fall with phase zero, first clock edge otherwise.
// - Slave drives data out only while select is low.
// - Phase zero: slave presents most significant bit before first edge.
// - Phase one: first clock edge starts transfer; select may stay low.
// - Polarity sets idle clock level; phase picks transfer format.
// - Master phase zero: clock idle first half; phase one: starts with edge.
// - Rate divider runs only when enable and master-select are both set.
module spims_core
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // AXI4-Lite write
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Serial link
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe,
    output logic             mosi_o,
    output logic             mosi_oe,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe,
    input  wire logic        miso_i,
    input  wire logic        select_n_i
);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT} spims_state_e;

    function automatic logic addr_is(input logic [9:0] a, input logic [9:0] r);
        return a[9:2] == r[9:2];
    endfunction

    spims_pkg::spims_cfg_s cfg;
    logic [7:0]  ctl_q;
    logic [1:0]  rate_q;
    logic [7:0]  tx_buf_q;
    logic        tx_full_q;
    logic [7:0]  shift_q;
    logic [7:0]  rx_q;
    logic        rxf_q;
    logic        rxf_armed_q;
    logic [3:0]  bits_q;
    logic        sclk_q;
    logic        phase_q;
    spims_state_e st_q;
    logic        half_tick;
    logic        sclk_prev_q;
    logic        sel_prev_q;
    logic        miso_q;

    assign cfg.enable = ctl_q[spims_pkg::CTL_EN_BIT];
    assign cfg.master = ctl_q[spims_pkg::CTL_MSTR_BIT];
    assign cfg.clock_polarity_bit   = ctl_q[spims_pkg::CTL_CLOCK_POLARITY_BIT_BIT];
    assign cfg.clock_phase_bit   = ctl_q[spims_pkg::CTL_CLOCK_PHASE_BIT_BIT];
    assign cfg.rate   = rate_q;

    // Bus handshakes
    logic wr_go;
    logic rd_go;
    logic wr_data;
    logic rd_data;
    logic rd_status;
    assign wr_go     = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    assign rd_go     = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    assign wr_data   = wr_go && addr_is(s_axi_awaddr, spims_pkg::ADDR_SERIAL_DATA) && s_axi_wstrb[0];
    assign rd_data   = rd_go && addr_is(s_axi_araddr, spims_pkg::ADDR_SERIAL_DATA);
    assign rd_status = rd_go && addr_is(s_axi_araddr, spims_pkg::ADDR_SERIAL_STATUS_CONTROL);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= spims_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (addr_is(s_axi_awaddr, spims_pkg::ADDR_SERIAL_CONTROL) ||
                                 addr_is(s_axi_awaddr, spims_pkg::ADDR_SERIAL_STATUS_CONTROL) ||
                                 addr_is(s_axi_awaddr, spims_pkg::ADDR_SERIAL_DATA))
                                ? spims_pkg::RESP_OKAY : spims_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= spims_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= rd_go;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= spims_pkg::RESP_OKAY;
                if (addr_is(s_axi_araddr, spims_pkg::ADDR_SERIAL_CONTROL))
                    s_axi_rdata <= {24'h000000, ctl_q};
                else if (rd_status)
                    s_axi_rdata <= {24'h000000, rxf_q, 3'h0, !tx_full_q, st_q != ST_IDLE, rate_q};
                else if (rd_data)
                    s_axi_rdata <= {24'h000000, rx_q};
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= spims_pkg::RESP_SLVERR;
                end
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Control registers; mode, polarity and phase bits
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ctl_q  <= spims_pkg::CTL_RESET;
            rate_q <= spims_pkg::RATE_RESET;
        end
        else
        begin
            if (wr_go && s_axi_wstrb[0] && addr_is(s_axi_awaddr, spims_pkg::ADDR_SERIAL_CONTROL))
                ctl_q <= s_axi_wdata[7:0] & 8'h2f;
            else if (wr_data)
                ctl_q[spims_pkg::CTL_TIE_BIT] <= 1'b0;
            if (wr_go && s_axi_wstrb[0] && addr_is(s_axi_awaddr, spims_pkg::ADDR_SERIAL_STATUS_CONTROL))
                rate_q <= s_axi_wdata[1:0];
        end
    end

    spims_rate_div u_div
    (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .run       (cfg.enable && cfg.master),
        .rate      (cfg.rate),
        .half_tick (half_tick)
    );

    // Slave pin edge detection; pins are taken as synchronous
    logic sclk_act;
    logic sclk_edge;
    logic lead_edge;
    logic sel_fall;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sclk_prev_q <= 1'b0;
            sel_prev_q  <= 1'b1;
        end
        else
        begin
            sclk_prev_q <= serial_clock_pin_i;
            sel_prev_q  <= select_n_i;
        end
    end
    // one sample per bus cycle catches clocks up to half the bus rate
    assign sclk_edge = serial_clock_pin_i != sclk_prev_q;
    assign sclk_act  = serial_clock_pin_i ^ cfg.clock_polarity_bit;
    assign lead_edge = sclk_edge && sclk_act;
    assign sel_fall  = sel_prev_q && !select_n_i;

    // Shift engine. phase_q tracks which half of a bit comes next.
    logic done;
    logic [7:0] rx_next;
    logic samp_ev;
    logic shift_ev;
    always_comb
    begin
        samp_ev  = 1'b0;
        shift_ev = 1'b0;
        if (st_q == ST_SHIFT)
        begin
            if (cfg.master)
            begin
                samp_ev  = half_tick && !phase_q;
                shift_ev = half_tick && phase_q;
            end
            else if (!select_n_i)
            begin
                samp_ev  = sclk_edge && (sclk_act ^ cfg.clock_phase_bit);
                shift_ev = sclk_edge && !(sclk_act ^ cfg.clock_phase_bit);
            end
        end
    end
    assign rx_next = {shift_q[6:0], cfg.master ? miso_i : mosi_i};
    // Slave ends the cycle after its eighth sample: with phase one no further edge follows it
    assign done    = (st_q == ST_SHIFT) && (bits_q == spims_pkg::BITS_PER_BYTE) && (!cfg.master || shift_ev);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_q      <= ST_IDLE;
            shift_q   <= 8'h00;
            tx_buf_q  <= 8'h00;
            tx_full_q <= 1'b0;
            bits_q    <= 4'h0;
            sclk_q    <= 1'b0;
            phase_q   <= 1'b0;
            miso_q    <= 1'b0;
        end
        else if (!cfg.enable)
        begin
            st_q    <= ST_IDLE;
            sclk_q  <= cfg.clock_polarity_bit;
            bits_q  <= 4'h0;
        end
        else
        begin
            // writes land in the buffer; shifter keeps old byte if none
            if (wr_data)
            begin
                tx_buf_q  <= s_axi_wdata[7:0];
                tx_full_q <= 1'b1;
            end
            case (st_q)
                ST_IDLE:
                begin
                    sclk_q  <= cfg.clock_polarity_bit;
                    bits_q  <= 4'h0;
                    // empty shifter takes the byte at once
                    if (tx_full_q && !wr_data)
                    begin
                        shift_q   <= tx_buf_q;
                        tx_full_q <= 1'b0;
                        if (cfg.master)
                            st_q <= ST_WAIT;
                    end
                    if (!cfg.master && !select_n_i && (cfg.clock_phase_bit ? lead_edge : sel_fall))
                    begin
                        st_q    <= ST_SHIFT;
                        bits_q  <= 4'h0;
                        phase_q <= 1'b0;
                        miso_q  <= shift_q[7];
                    end
                end
                ST_WAIT:
                begin
                    // start aligned to divider tick, within one bit time
                    if (half_tick)
                    begin
                        st_q    <= ST_SHIFT;
                        // phase one opens with an edge
                        sclk_q  <= cfg.clock_phase_bit ? !cfg.clock_polarity_bit : cfg.clock_polarity_bit;
                        // Both phases sample on the next tick; msb goes out now
                        phase_q <= 1'b0;
                        miso_q  <= shift_q[7];
                        bits_q  <= 4'h0;
                    end
                end
                ST_SHIFT:
                begin
                    if (cfg.master && half_tick && !(done))
                        sclk_q <= !sclk_q;
                    if (cfg.master && half_tick)
                        phase_q <= !phase_q;
                    if (samp_ev)
                    begin
                        shift_q <= rx_next;
                        bits_q  <= bits_q + 4'h1;
                    end
                    if (shift_ev && !done)
                        miso_q <= shift_q[7];
                    if (done)
                    begin
                        st_q   <= ST_IDLE;
                        sclk_q <= cfg.clock_polarity_bit;
                    end
                    // slave aborts if select rises mid-byte
                    if (!cfg.master && select_n_i)
                        st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // receive register and flag move together
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rx_q        <= 8'h00;
            rxf_q       <= 1'b0;
            rxf_armed_q <= 1'b0;
        end
        else
        begin
            if (rd_status)
                rxf_armed_q <= rxf_q;
            // status then data read clears; new byte wins
            if (done)
            begin
                rx_q  <= shift_q;
                rxf_q <= 1'b1;
            end
            else if (rd_data && rxf_armed_q)
            begin
                rxf_q       <= 1'b0;
                rxf_armed_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            serial_clock_pin_o  <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
            mosi_o              <= 1'b0;
            mosi_oe             <= 1'b0;
            miso_o              <= 1'b0;
            miso_oe             <= 1'b0;
        end
        else
        begin
            serial_clock_pin_o  <= sclk_q;
            serial_clock_pin_oe <= cfg.enable && cfg.master;
            mosi_o              <= (st_q == ST_SHIFT) ? miso_q : shift_q[7];
            mosi_oe             <= cfg.enable && cfg.master;
            miso_o              <= (st_q == ST_SHIFT) ? miso_q : shift_q[7];
            miso_oe             <= cfg.enable && !cfg.master && !select_n_i;
        end
    end

    // Checks
    rxf_set_a: assert property (@(posedge ref_clk) disable iff (reset)
        done |=> rxf_q && rx_q == $past(shift_q)) else $error("receive flag not set at end");
    tie_clr_a: assert property (@(posedge ref_clk) disable iff (reset)
        wr_data |=> !ctl_q[spims_pkg::CTL_TIE_BIT]) else $error("irq enable not cleared");
    div_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
        !(cfg.enable && cfg.master) |=> u_div.cnt_q == 7'h00) else $error("divider runs while gated");
    miso_oe_a: assert property (@(posedge ref_clk) disable iff (reset)
        miso_oe |-> $past(!select_n_i) && !$past(cfg.master)) else $error("miso driven unselected");
    sclk_in_a: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg.master |=> !serial_clock_pin_oe) else $error("slave drives clock");
    start_lat_a: assert property (@(posedge ref_clk) disable iff (reset)
        st_q == ST_WAIT && rate_q == 2'h0 |-> ##[1:2] st_q != ST_WAIT) else $error("start too slow");
    slave_start_a: assert property (@(posedge ref_clk) disable iff (reset)
        st_q == ST_IDLE && cfg.enable && !cfg.master && cfg.clock_phase_bit && lead_edge && !select_n_i
        |=> st_q == ST_SHIFT) else $error("slave phase one start missed");
    mst_only_a: assert property (@(posedge ref_clk) disable iff (reset)
        st_q == ST_WAIT |-> cfg.master) else $error("slave initiated");
    rxf_clr_a: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(rxf_q) |-> $past(rd_data)) else $error("receive flag cleared without read");
    idle_pol_a: assert property (@(posedge ref_clk) disable iff (reset)
        st_q == ST_IDLE |=> sclk_q == $past(cfg.clock_polarity_bit)) else $error("idle clock level wrong");

    master_xfer_c: cover property (@(posedge ref_clk) disable iff (reset) done && cfg.master);
    slave_xfer_c:  cover property (@(posedge ref_clk) disable iff (reset) done && !cfg.master);
    rxf_clear_c:   cover property (@(posedge ref_clk) disable iff (reset) $fell(rxf_q));

endmodule // spims_core

// ===== src/spims_pkg.sv
package spims_pkg;

    // Register byte addresses on the AXI4-Lite slave
    localparam logic [7:0] OFF_SERIAL_CONTROL        = 8'h10;
    localparam logic [7:0] OFF_SERIAL_STATUS_CONTROL = 8'h11;
    localparam logic [7:0] OFF_SERIAL_DATA           = 8'h12;
    localparam logic [9:0] ADDR_SERIAL_CONTROL        = {OFF_SERIAL_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_SERIAL_STATUS_CONTROL = {OFF_SERIAL_STATUS_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_SERIAL_DATA           = {OFF_SERIAL_DATA, 2'b00};

    // serial_control field positions
    localparam int CTL_TIE_BIT  = 5;
    localparam int CTL_MSTR_BIT = 3;
    localparam int CTL_CLOCK_POLARITY_BIT_BIT = 2;
    localparam int CTL_CLOCK_PHASE_BIT_BIT = 1;
    localparam int CTL_EN_BIT   = 0;

    // serial_status_control field positions
    localparam int STS_RXF_BIT  = 7;
    localparam int STS_TXE_BIT  = 3;
    localparam int STS_BUSY_BIT = 2;
    localparam int STS_RATE_HI  = 1;
    localparam int STS_RATE_LO  = 0;

    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [1:0] RATE_RESET = 2'h0;

    // Half bit times in bus cycles for rates 2, 8, 32, 128
    localparam logic [6:0] HALF_RATE_HALF   = 7'h01;
    localparam logic [6:0] HALF_RATE_EIGHTH = 7'h04;
    localparam logic [6:0] HALF_RATE_32     = 7'h10;
    localparam logic [6:0] HALF_RATE_128    = 7'h40;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       enable;
        logic       master;
        logic       clock_polarity_bit;
        logic       clock_phase_bit;
        logic [1:0] rate;
    } spims_cfg_s;

endpackage

// ===== src/spims_rate_div.sv
`timescale 1ns/1ps
// Divider gated by run, giving a one-cycle tick every half bit time
module spims_rate_div
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] rate,
    // Tick
    output logic            half_tick
);

    logic [6:0] cnt_q;
    logic [6:0] half_len;

    always_comb
    begin
        case (rate)
            2'h0: half_len = spims_pkg::HALF_RATE_HALF;
            2'h1: half_len = spims_pkg::HALF_RATE_EIGHTH;
            2'h2: half_len = spims_pkg::HALF_RATE_32;
            default: half_len = spims_pkg::HALF_RATE_128;
        endcase
    end

    // Stopped divider saves power
    always_ff @(posedge ref_clk)
    begin
        if (reset || !run)
            cnt_q <= 7'h00;
        else if (cnt_q >= half_len - 7'h01)
            cnt_q <= 7'h00;
        else
            cnt_q <= cnt_q + 7'h01;
    end

    assign half_tick = run && (cnt_q >= half_len - 7'h01);

endmodule // spims_rate_div

// ===== verif/spims_peer.sv
`timescale 1ns/1ps
// Behavioural peripheral that answers a master transfer
module spims_peer
(
    // Link
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       clock_polarity_bit,
    input  wire logic       clock_phase_bit,
    // Bytes
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh = 8'h00;
    logic [3:0] n  = 4'h0;
    always @(negedge sel_n)
    begin
        sh <= tx_byte;
        n  <= 4'h0;
    end
    always @(sclk)
        if (!sel_n && ((sclk != clock_polarity_bit) != clock_phase_bit))
        begin
            rx_byte <= {rx_byte[6:0], mosi};
            n       <= n + 4'h1;
        end
    // msb before first edge; a released line shows the inverted lsb
    assign miso = sel_n ? ~sh[0] : sh[3'd7 - n[2:0]];
endmodule // spims_peer

// ===== verif/spi_master_slave_core_tb.sv
`timescale 1ns/1ps
module spi_master_slave_core_tb;
    localparam logic [9:0] A_CTL = spims_pkg::ADDR_SERIAL_CONTROL;
    localparam logic [9:0] A_STS = spims_pkg::ADDR_SERIAL_STATUS_CONTROL;
    localparam logic [9:0] A_DAT = spims_pkg::ADDR_SERIAL_DATA;
    logic        ref_clk = 1'b0, reset = 1'b1;
    logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        sclk = 1'b0, mosi = 1'b0, sel_n = 1'b1, psel_n = 1'b1, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0;
    logic [7:0]  ptx = 8'h00, prx;
    logic        awready, wready, bvalid, arready, rvalid, sco, scoe, mo, moe, so, soe, pmiso;
    logic [1:0]  bresp, rresp;
    logic [15:0] seed = 16'h6147;
    logic [31:0] d;
    logic [1:0]  r;
    int          n_fail = 0;
    int          num_checks = 0;
    wire logic   sc_line = scoe ? sco : sclk;
    wire logic   mo_line = moe ? mo : mosi;
    wire logic   so_line = soe ? so : pmiso;

    always #5 ref_clk = ~ref_clk;

    spims_core u_spims_core (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clock_pin_i(sc_line),
        .serial_clock_pin_o(sco), .serial_clock_pin_oe(scoe), .mosi_o(mo), .mosi_oe(moe), .mosi_i(mo_line),
        .miso_o(so), .miso_oe(soe), .miso_i(so_line), .select_n_i(sel_n));

    spims_peer u_spims_peer (.sclk(sc_line), .mosi(mo_line), .sel_n(psel_n), .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit),
        .tx_byte(ptx), .miso(pmiso), .rx_byte(prx));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] ctl(input logic en, ms, po, ph, tie);
        logic [31:0] v;
        v = 32'h0;
        v[spims_pkg::CTL_EN_BIT]   = en;
        v[spims_pkg::CTL_MSTR_BIT] = ms;
        v[spims_pkg::CTL_CLOCK_POLARITY_BIT_BIT] = po;
        v[spims_pkg::CTL_CLOCK_PHASE_BIT_BIT] = ph;
        v[spims_pkg::CTL_TIE_BIT]  = tie;
        return v;
    endfunction

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic tmo();
        n_fail++;
        $display("Error at %0t: got %h exp %h", $time, 1'b0, 1'b1);
        final_report();
    endtask

    task automatic axi_wr(input logic [9:0] a, input logic [31:0] v);
        logic aw, w, b;
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int i = 0; i < 50; i++)
        begin
            @(negedge ref_clk);
            aw = awready;
            w  = wready;
            b  = bvalid;
            r  = bresp;
            @(posedge ref_clk);
            if (aw)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
            if (b)
            begin
                bready <= 1'b0;
                @(posedge ref_clk);
                return;
            end
        end
        tmo();
    endtask

    task automatic axi_rd(input logic [9:0] a);
        logic ar, rv;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int i = 0; i < 50; i++)
        begin
            @(negedge ref_clk);
            ar = arready;
            rv = rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge ref_clk);
            if (ar)
                arvalid <= 1'b0;
            if (rv)
            begin
                rready <= 1'b0;
                @(posedge ref_clk);
                return;
            end
        end
        tmo();
    endtask

    task automatic xfer_m(input int k);
        logic [7:0] b;
        seed = lfsr(seed);
        b    = seed[7:0];
        seed = lfsr(seed);
        ptx  <= seed[7:0];
        clock_polarity_bit <= k[0];
        clock_phase_bit <= k[1];
        axi_wr(A_CTL, ctl(1'b0, 1'b1, k[0], k[1], 1'b0));
        axi_wr(A_STS, 32'(k));
        axi_wr(A_CTL, ctl(1'b1, 1'b1, k[0], k[1], 1'b1));
        psel_n <= 1'b0;
        axi_wr(A_DAT, {24'h0, b});
        axi_rd(A_CTL);
        chk(d, ctl(1'b1, 1'b1, k[0], k[1], 1'b0));
        for (int i = 0; i < 800 && d[spims_pkg::STS_RXF_BIT] !== 1'b1; i++)
            axi_rd(A_STS);
        chk(32'(d[spims_pkg::STS_RXF_BIT]), 32'h1);
        chk(32'(d[spims_pkg::STS_TXE_BIT]), 32'h1);
        chk(32'(d[1:0]), 32'(k));
        axi_rd(A_DAT);
        chk(d, {24'h0, ptx});
        chk({24'h0, prx}, {24'h0, b});
        axi_rd(A_STS);
        chk(32'(d[spims_pkg::STS_RXF_BIT]), 32'h0);
        psel_n <= 1'b1;
    endtask

    task automatic xfer_s(input logic ph);
        logic [7:0] m, t, s;
        seed = lfsr(seed);
        m    = seed[7:0];
        seed = lfsr(seed);
        t    = seed[7:0];
        axi_wr(A_CTL, ctl(1'b0, 1'b0, 1'b0, ph, 1'b0));
        axi_wr(A_CTL, ctl(1'b1, 1'b0, 1'b0, ph, 1'b0));
        axi_wr(A_DAT, {24'h0, t});
        chk({30'h0, scoe, moe}, 32'h0);
        chk(32'(soe), 32'h0);
        sel_n <= 1'b0;
        // bench master at an eighth of the bus clock
        for (int k = 7; k >= 0; k--)
        begin
            if (!ph)
                mosi <= m[k];
            repeat (4) @(posedge ref_clk);
            if (!ph)
                s[k] = so_line;
            sclk <= 1'b1;
            if (ph)
                mosi <= m[k];
            repeat (4) @(posedge ref_clk);
            if (ph)
                s[k] = so_line;
            sclk <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        sel_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(32'(soe), 32'h0);
        chk({24'h0, s}, {24'h0, t});
        axi_rd(A_STS);
        chk(32'(d[spims_pkg::STS_RXF_BIT]), 32'h1);
        axi_rd(A_DAT);
        chk(d, {24'h0, m});
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        axi_rd(A_CTL);
        chk(d, {24'h0, spims_pkg::CTL_RESET});
        chk(32'(r), 32'(spims_pkg::RESP_OKAY));
        axi_rd(A_STS);
        chk(d, (32'h1 << spims_pkg::STS_TXE_BIT) | 32'(spims_pkg::RATE_RESET));
        axi_rd(10'h3fc);
        chk({d[29:0], r}, {30'h0, spims_pkg::RESP_SLVERR});
        axi_wr(10'h3f0, 32'h5a);
        chk(32'(r), 32'(spims_pkg::RESP_SLVERR));
        $display("Test registers done");
        // own select held high as master
        for (int k = 0; k < 4; k++)
            xfer_m(k);
        $display("Test master done");
        xfer_s(1'b0);
        xfer_s(1'b1);
        $display("Test slave done");
        final_report();
    end
endmodule // spi_master_slave_core_tb
